//--- hdl/usb_host_transaction_status.sv
/*
 * Per-transaction command and result registers of two USB host serial
 * engines, reached over AXI4-Lite. Assumes the serial engine itself
 * reports each finished transaction as a one-cycle pulse with its
 * outcome on the same cycle, all synchronous to aclk.
 */
// The implementer's own choice: the AXI4-Lite slave port.

// Summary of operation
// - Overflow bit 11 set when received data exceeded the byte count.
// - Underflow bit 10 set when received data fell short of the count.
// - Length bit 5 set on either overflow or underflow.
// - Stall bit 7 reflects a STALL answer in the last transaction.
// - NAK bit 6 reflects a NAK answer in the last transaction.
// - Toggle bit 3 reports DATA1 as one, DATA0 as zero.
// - On a transaction error toggle is forced zero and error set.
// - Timeout bit 2 set when the peripheral answered too late.
// - Error bit 1 set on CRC failures or unexpected packet types.
// - Length mismatch never touches the error bit.
// - ACK bit 0 on ACK, or on clean isochronous completion.
// - Write-only token register: bits 7..4 token, 3..0 endpoint.
// - Token selector codes SETUP, IN, OUT, SOF, PRE, NAK, STALL, DATA.
// - ACK handshakes come from the engine, not the selector.
// - Four-bit endpoint number reaches any of 16 endpoints.
// - Sixteen-bit read-only result holds count minus received length after IN, zero otherwise.
// - Overflow result is negative, bits 15..11 all ones.
// - Underflow result is the count of unused programmed bytes.
// - Write-only target address, bits 6..0, upper bits reserved.
// - Result reads and address writes share one location per engine.
// - Status reads and token writes share one location per engine.
// - Ten-bit byte count is the reference for every comparison.
// - Arm bit starts a transaction and clears itself on completion.
module usb_host_transaction_status
    import usb_host_transaction_status_pkg::*;
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [AXI_ADDR_W-1:0]         s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0]         s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic [ENGINES-1:0]            xfer_done,
    input  wire logic [ENGINES-1:0]            rx_ack,
    input  wire logic [ENGINES-1:0]            rx_nak,
    input  wire logic [ENGINES-1:0]            rx_stall,
    input  wire logic [ENGINES-1:0]            rx_timeout,
    input  wire logic [ENGINES-1:0]            rx_crc_error,
    input  wire logic [ENGINES-1:0]            rx_bad_pid,
    input  wire logic [ENGINES-1:0]            rx_data1,
    input  wire logic [ENGINES-1:0][RXLEN_W-1:0] rx_length,
    output logic [ENGINES-1:0]                 arm,
    output logic [ENGINES-1:0]                 iso_mode,
    output logic [ENGINES-1:0]                 sof_sync,
    output logic [ENGINES-1:0]                 send_data1,
    output logic [ENGINES-1:0]                 preamble_en,
    output logic [ENGINES-1:0]                 port_b_sel,
    output logic [ENGINES-1:0][COUNT_W-1:0]    byte_count,
    output logic [ENGINES-1:0][3:0]            token_selector,
    output logic [ENGINES-1:0][3:0]            endpoint,
    output logic [ENGINES-1:0]                 token_legal,
    output logic [ENGINES-1:0][ADDR7_W-1:0]    target_address
);

    // ==================================================================
    // Helpers.
    function automatic reg_sel_type reg_decode(
        input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] off;
        off = idx - IDX_BASE;
        reg_decode = SEL_NONE;
        if (idx >= IDX_BASE && off < IDX_SPAN) begin
            case (off[4:0])
                OFF_CONTROL:      reg_decode = SEL_CTRL;
                OFF_COUNT:        reg_decode = SEL_COUNT;
                OFF_STATUS_TOKEN: reg_decode = SEL_STATUS;
                OFF_RESULT_ADDR:  reg_decode = SEL_RESULT;
                default:          reg_decode = SEL_NONE;
            endcase
        end
    endfunction

    function automatic logic engine_of(input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] off;
        off = idx - IDX_BASE;
        engine_of = off[ENGINE_BIT];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = data[15:8];
        end
    endfunction

    function automatic logic pid_known(input logic [3:0] pid);
        case (pid)
            PID_SETUP, PID_IN, PID_OUT, PID_SOF, PID_PREAMBLE,
            PID_NAK, PID_STALL, PID_DATA0, PID_DATA1: pid_known = 1'b1;
            default:                                  pid_known = 1'b0;
        endcase
    endfunction

    // ==================================================================
    // AXI4-Lite slave. Address and data are taken together in one beat.
    logic        awready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;

    wire logic [IDX_W-1:0] w_idx   = s_axi_awaddr[AXI_ADDR_W-1:2];
    wire logic [IDX_W-1:0] r_idx   = s_axi_araddr[AXI_ADDR_W-1:2];
    wire reg_sel_type      w_sel   = reg_decode(w_idx);
    wire reg_sel_type      r_sel   = reg_decode(r_idx);
    wire logic             w_eng   = engine_of(w_idx);
    wire logic             r_eng   = engine_of(r_idx);
    wire logic             wr_go   = s_axi_awvalid & s_axi_wvalid &
                                     awready_r;
    wire logic             rd_go   = s_axi_arvalid & arready_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            awready_r <= ~awready_r & s_axi_awvalid & s_axi_wvalid &
                         ~bvalid_r;
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (w_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Per-engine registers and transaction completion.
    logic [ENGINES-1:0][15:0] ctrl_r;
    logic [ENGINES-1:0][15:0] count_r;
    logic [ENGINES-1:0][7:0]  token_r;
    logic [ENGINES-1:0]       legal_r;
    logic [ENGINES-1:0][6:0]  addr_r;
    logic [ENGINES-1:0][15:0] status_r;
    logic [ENGINES-1:0][15:0] result_r;
    logic [ENGINES-1:0]       done_w;
    logic [ENGINES-1:0]       rx_dir_w;

    genvar e;
    for (e = 0; e < ENGINES; e++) begin : g_eng
        wire logic wr_me  = wr_go & (w_eng == 1'(e));
        wire logic done   = xfer_done[e] & ctrl_r[e][CTL_ARM];
        wire logic err    = rx_crc_error[e] | rx_bad_pid[e];
        wire logic iso    = ctrl_r[e][CTL_ISO];
        // Only an IN transaction has a data stage to measure.
        wire logic rx_dir = token_r[e][7:4] == PID_IN;
        wire logic [RXLEN_W-1:0] cnt = {1'b0, count_r[e][COUNT_W-1:0]};
        wire logic over   = rx_dir & (rx_length[e] > cnt);
        wire logic under  = rx_dir & (rx_length[e] < cnt);
        wire logic ack    = iso ? ~(err | rx_timeout[e])
                                : rx_ack[e] & ~err;
        wire logic [15:0] diff = 16'(cnt) - 16'(rx_length[e]);
        logic [15:0] st_nxt;
        logic [15:0] ctrl_nxt;

        assign done_w[e]   = done;
        assign rx_dir_w[e] = rx_dir;

        always_comb begin
            st_nxt               = REG_RESET;
            st_nxt[ST_OVERFLOW]  = over;
            st_nxt[ST_UNDERFLOW] = under;
            st_nxt[ST_LENGTH]    = over | under;
            st_nxt[ST_STALL]     = rx_stall[e];
            st_nxt[ST_NAK]       = rx_nak[e];
            st_nxt[ST_TOGGLE]    = rx_data1[e] & ~err;
            st_nxt[ST_TIMEOUT]   = rx_timeout[e];
            st_nxt[ST_ERROR]     = err;
            st_nxt[ST_ACK]       = ack;
        end

        // A firmware write that re-arms wins over the completion clear.
        always_comb begin
            ctrl_nxt = ctrl_r[e];
            if (wr_me && w_sel == SEL_CTRL) begin
                ctrl_nxt = merge16(ctrl_r[e], s_axi_wdata, s_axi_wstrb) &
                           CTL_MASK;
            end else if (done) begin
                ctrl_nxt[CTL_ARM] = 1'b0;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctrl_r[e]   <= REG_RESET;
                count_r[e]  <= REG_RESET;
                token_r[e]  <= REG_RESET[7:0];
                legal_r[e]  <= 1'b0;
                addr_r[e]   <= REG_RESET[6:0];
                status_r[e] <= REG_RESET;
                result_r[e] <= REG_RESET;
            end else begin
                ctrl_r[e] <= ctrl_nxt;
                if (wr_me && w_sel == SEL_COUNT) begin
                    count_r[e] <= merge16(count_r[e], s_axi_wdata,
                                          s_axi_wstrb) & COUNT_MASK;
                end
                if (wr_me && w_sel == SEL_STATUS && s_axi_wstrb[0]) begin
                    token_r[e] <= s_axi_wdata[7:0];
                    legal_r[e] <= pid_known(s_axi_wdata[7:4]);
                end
                if (wr_me && w_sel == SEL_RESULT && s_axi_wstrb[0]) begin
                    addr_r[e] <= s_axi_wdata[ADDR7_W-1:0];
                end
                if (done) begin
                    status_r[e] <= st_nxt;
                    result_r[e] <= rx_dir ? diff : REG_RESET;
                end
            end
        end

        assign arm[e]            = ctrl_r[e][CTL_ARM];
        assign iso_mode[e]       = ctrl_r[e][CTL_ISO];
        assign sof_sync[e]       = ctrl_r[e][CTL_SYNC];
        assign send_data1[e]     = ctrl_r[e][CTL_SEQ];
        assign preamble_en[e]    = ctrl_r[e][CTL_PREAMBLE];
        assign port_b_sel[e]     = count_r[e][CNT_PORT_SEL];
        assign byte_count[e]     = count_r[e][COUNT_W-1:0];
        assign token_selector[e] = token_r[e][7:4];
        assign endpoint[e]       = token_r[e][3:0];
        assign token_legal[e]    = legal_r[e];
        assign target_address[e] = addr_r[e];
    end

    // ==================================================================
    // Read path. Write-only registers share locations with read-only ones.
    wire logic [15:0] rd_val =
        (r_sel == SEL_CTRL)   ? ctrl_r[r_eng]   :
        (r_sel == SEL_COUNT)  ? count_r[r_eng]  :
        (r_sel == SEL_STATUS) ? status_r[r_eng] :
        (r_sel == SEL_RESULT) ? result_r[r_eng] :
                                REG_RESET;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            arready_r <= ~arready_r & s_axi_arvalid & ~rvalid_r;
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rdata_r  <= {16'h0000, rd_val};
                rresp_r  <= (r_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = awready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // ==================================================================
    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_OVERFLOW: assert property (
        done_w[0] && rx_dir_w[0] && rx_length[0] > 11'(byte_count[0])
        |=> status_r[0][ST_OVERFLOW] && !status_r[0][ST_UNDERFLOW])
        else $error("overflow not flagged");
    AST_UNDERFLOW: assert property (
        done_w[0] && rx_dir_w[0] && rx_length[0] < 11'(byte_count[0])
        |=> status_r[0][ST_UNDERFLOW] && !status_r[0][ST_OVERFLOW])
        else $error("underflow not flagged");
    AST_LENGTH: assert property (
        status_r[0][ST_LENGTH] ==
        (status_r[0][ST_OVERFLOW] | status_r[0][ST_UNDERFLOW]))
        else $error("length bit disagrees with over and under");
    AST_STALL_NAK: assert property (
        done_w[0] |=> status_r[0][ST_STALL] == $past(rx_stall[0]) &&
                      status_r[0][ST_NAK] == $past(rx_nak[0]))
        else $error("stall or nak bit wrong");
    AST_TOGGLE_ERR: assert property (
        done_w[0] && (rx_crc_error[0] || rx_bad_pid[0])
        |=> !status_r[0][ST_TOGGLE] && status_r[0][ST_ERROR])
        else $error("toggle not cleared on error");
    AST_TIMEOUT: assert property (
        done_w[0] && rx_timeout[0] |=> status_r[0][ST_TIMEOUT])
        else $error("timeout not flagged");
    AST_NO_LEN_ERR: assert property (
        done_w[0] && !rx_crc_error[0] && !rx_bad_pid[0]
        |=> !status_r[0][ST_ERROR])
        else $error("error bit set without cause");
    AST_ISO_ACK: assert property (
        done_w[0] && iso_mode[0] && !rx_timeout[0] && !rx_crc_error[0] &&
        !rx_bad_pid[0] |=> status_r[0][ST_ACK])
        else $error("isochronous success not acknowledged");
    AST_NEG_RESULT: assert property (
        status_r[0][ST_OVERFLOW] |-> result_r[0][15:10] == RESULT_NEG_MARK)
        else $error("overflow result not negative");
    AST_ARM_CLEAR: assert property (
        done_w[0] && !(wr_go && w_sel == SEL_CTRL) |=> !arm[0] [*2])
        else $error("arm not cleared after completion");
    AST_TOKEN: assert property (
        wr_go && w_sel == SEL_STATUS && !w_eng && s_axi_wstrb[0]
        |=> token_selector[0] == $past(s_axi_wdata[7:4]) &&
            endpoint[0] == $past(s_axi_wdata[3:0]))
        else $error("token register not loaded");
    AST_READ_ANSWER: assert property (
        rd_go |=> s_axi_rvalid)
        else $error("read answer dropped");
    AST_READ_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer withdrawn before it was taken");

    COV_OVERFLOW: cover property (done_w[0] && rx_dir_w[0] &&
                                  rx_length[0] > 11'(byte_count[0]));
    COV_UNDERFLOW: cover property (done_w[1] && rx_dir_w[1] &&
                                   rx_length[1] < 11'(byte_count[1]));
    COV_STALL: cover property (done_w[0] && rx_stall[0]);
    COV_READ_STATUS: cover property (rd_go && r_sel == SEL_STATUS);

endmodule

//--- inc/usb_host_transaction_status_pkg.sv
/*
 * Constants, register indices and types of the USB host transaction
 * command and result block. Assumes an AXI4-Lite register bus with
 * 32-bit data and registers that each occupy one aligned word.
 */
package usb_host_transaction_status_pkg;

    // ==================================================================
    // Register map: printed indices, byte address is four times these.
    localparam int           ENGINES          = 2;
    localparam int           AXI_ADDR_W       = 20;
    localparam int           IDX_W            = 18;
    localparam logic [17:0]  IDX_BASE         = 18'h0c080;
    localparam logic [17:0]  IDX_H1_CONTROL   = 18'h0c080;
    localparam logic [17:0]  IDX_H1_COUNT     = 18'h0c084;
    localparam logic [17:0]  IDX_H1_STATUS    = 18'h0c086;
    localparam logic [17:0]  IDX_H1_RESULT    = 18'h0c088;
    localparam logic [17:0]  IDX_H2_CONTROL   = 18'h0c0a0;
    localparam logic [17:0]  IDX_H2_STATUS    = 18'h0c0a6;
    localparam logic [17:0]  IDX_H2_RESULT    = 18'h0c0a8;
    localparam logic [17:0]  IDX_SPAN         = 18'h00040;
    localparam int           ENGINE_BIT       = 5;
    localparam logic [4:0]   OFF_CONTROL      = 5'h00;
    localparam logic [4:0]   OFF_COUNT        = 5'h04;
    localparam logic [4:0]   OFF_STATUS_TOKEN = 5'h06;
    localparam logic [4:0]   OFF_RESULT_ADDR  = 5'h08;

    // ==================================================================
    // Field layouts.
    localparam int           ST_OVERFLOW      = 11;
    localparam int           ST_UNDERFLOW     = 10;
    localparam int           ST_STALL         = 7;
    localparam int           ST_NAK           = 6;
    localparam int           ST_LENGTH        = 5;
    localparam int           ST_TOGGLE        = 3;
    localparam int           ST_TIMEOUT       = 2;
    localparam int           ST_ERROR         = 1;
    localparam int           ST_ACK           = 0;
    localparam int           CTL_ARM          = 0;
    localparam int           CTL_ISO          = 4;
    localparam int           CTL_SYNC         = 5;
    localparam int           CTL_SEQ          = 6;
    localparam int           CTL_PREAMBLE     = 7;
    localparam logic [15:0]  CTL_MASK         = 16'h00f1;
    localparam int           COUNT_W          = 10;
    localparam int           CNT_PORT_SEL     = 14;
    localparam logic [15:0]  COUNT_MASK       = 16'h43ff;
    localparam int           RXLEN_W          = 11;
    localparam int           ADDR7_W          = 7;
    localparam logic [15:0]  REG_RESET        = 16'h0000;
    localparam logic [5:0]   RESULT_NEG_MARK  = 6'h3f;

    // ==================================================================
    // Token selector codes.
    localparam logic [3:0]   PID_SETUP        = 4'hd;
    localparam logic [3:0]   PID_IN           = 4'h9;
    localparam logic [3:0]   PID_OUT          = 4'h1;
    localparam logic [3:0]   PID_SOF          = 4'h5;
    localparam logic [3:0]   PID_PREAMBLE     = 4'hc;
    localparam logic [3:0]   PID_NAK          = 4'ha;
    localparam logic [3:0]   PID_STALL        = 4'he;
    localparam logic [3:0]   PID_DATA0        = 4'h3;
    localparam logic [3:0]   PID_DATA1        = 4'hb;

    // ==================================================================
    // Bus answers.
    localparam logic [1:0]   RESP_OKAY        = 2'b00;
    localparam logic [1:0]   RESP_SLVERR      = 2'b10;

    typedef enum logic [2:0] {
        SEL_NONE   = 3'b000,
        SEL_CTRL   = 3'b001,
        SEL_COUNT  = 3'b010,
        SEL_STATUS = 3'b011,
        SEL_RESULT = 3'b100
    } reg_sel_type;

endpackage

//--- verification/usb_peripheral_model.sv
/*
 * Behavioural model of the peripheral side of both serial engines.
 * Assumes the bench sets the outcome flags, length and answer delay
 * before it arms a transaction.
 */
module usb_peripheral_model (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [1:0]        arm,
    input  wire logic [3:0]        dly,
    input  wire logic [6:0]        flags,
    input  wire logic [10:0]       len,
    output logic [1:0]             xfer_done,
    output logic [1:0][6:0]        outc,
    output logic [1:0][10:0]       rx_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0][4:0] cnt_r;

    // ==================================================================
    // Answer timing
    // The count stops one past dly, so one arming gives exactly one pulse.
    always_ff @(posedge aclk) begin
        for (int e = 0; e < 2; e++) begin
            cnt_r[e] <= (aresetn && arm[e]) ?
                        cnt_r[e] + {4'h0, cnt_r[e] <= {1'b0, dly}} : 5'h00;
            xfer_done[e] <= aresetn && arm[e] && cnt_r[e] == {1'b0, dly};
        end
    end

    // Outside the done cycle the lines show the inverse, so late sampling
    // in the design reads wrong values instead of stale good ones.
    assign outc   = {2{flags}} ^ {{7{~xfer_done[1]}}, {7{~xfer_done[0]}}};
    assign rx_len = {2{len}} ^ {{11{~xfer_done[1]}}, {11{~xfer_done[0]}}};
endmodule

//--- verification/tb_usb_host_transaction_status.sv
/*
 * Self-checking bench of the transaction command and result block.
 * Assumes the peripheral model answers every armed transaction.
 */
module tb_usb_host_transaction_status;
    timeunit 1ns;
    timeprecision 1ps;
    import usb_host_transaction_status_pkg::*;
    logic                aclk, aresetn, awvalid, wvalid, bready;
    logic                arvalid, rready, awready, wready, bvalid;
    logic                arready, rvalid;
    logic [19:0]         awaddr, araddr;
    logic [31:0]         wdata, rdata;
    logic [1:0]          bresp, rresp, xfer_done, arm, legal;
    logic [3:0]          dly;
    logic [6:0]          flags;
    logic [10:0]         len;
    logic [1:0][6:0]     outc, taddr;
    logic [1:0][10:0]    rx_len;
    logic [1:0][3:0]     tok, ep;
    logic [1:0]          iso, sync, seq, pre, pb;
    logic [1:0][9:0]     bcnt;
    int                  num_errors, samples_checked, cycles;

    usb_host_transaction_status uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .xfer_done(xfer_done), .rx_ack({outc[1][0], outc[0][0]}),
        .rx_nak({outc[1][1], outc[0][1]}), .rx_stall({outc[1][2], outc[0][2]}),
        .rx_timeout({outc[1][3], outc[0][3]}),
        .rx_crc_error({outc[1][4], outc[0][4]}),
        .rx_bad_pid({outc[1][5], outc[0][5]}),
        .rx_data1({outc[1][6], outc[0][6]}), .rx_length(rx_len), .arm(arm),
        .iso_mode(iso), .sof_sync(sync), .send_data1(seq), .preamble_en(pre),
        .port_b_sel(pb), .byte_count(bcnt), .token_selector(tok), .endpoint(ep),
        .token_legal(legal), .target_address(taddr));

    usb_peripheral_model peer (.aclk(aclk), .aresetn(aresetn), .arm(arm),
        .dly(dly), .flags(flags), .len(len), .xfer_done(xfer_done),
        .outc(outc), .rx_len(rx_len));

    // ==================================================================
    // Bus and checking tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [17:0] idx, input logic [15:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [17:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // One armed transaction with a byte count of ten, then the readback.
    task automatic txn(input logic e, input logic [15:0] ctl,
                       input logic [3:0] pid, input logic [6:0] f,
                       input logic [10:0] l, input logic [15:0] st,
                       input logic [15:0] res);
        logic [17:0] o;
        logic [1:0]  r;
        logic [31:0] d;
        o = e ? 18'h00020 : 18'h00000;
        flags <= f;
        len   <= l;
        wr(IDX_H1_COUNT + o, {1'b0, e, 14'h000a}, r);
        wr(IDX_H1_STATUS + o, {8'h00, pid, 4'h3}, r);
        wr(IDX_H1_CONTROL + o, ctl | 16'h0001, r);
        while (arm[e] !== 1'b0) @(posedge aclk);
        chk({pb[e], pre[e], seq[e], sync[e], iso[e], bcnt[e]},
            {e, ctl[7:4], 10'h00a});
        rd(IDX_H1_STATUS + o, d, r);
        chk(d, {16'h0000, st});
        rd(IDX_H1_RESULT + o, d, r);
        chk(d, {16'h0000, res});
        rd(IDX_H1_CONTROL + o, d, r);
        chk(d, {16'h0000, ctl});
    endtask

    // ==================================================================
    // Scenarios
    task automatic scn_length;
        dly <= 4'h0;
        txn(1'b1, 16'h00e0, PID_IN, 7'h41, 11'h00c, 16'h0829, 16'hfffe);
        txn(1'b0, 16'h0000, PID_IN, 7'h01, 11'h007, 16'h0421, 16'h0003);
        txn(1'b0, 16'h0000, PID_IN, 7'h51, 11'h00c, 16'h0822, 16'hfffe);
    endtask

    task automatic scn_handshakes;
        dly <= 4'h9;
        txn(1'b0, 16'h0000, PID_IN, 7'h02, 11'h00a, 16'h0040, 16'h0000);
        txn(1'b1, 16'h0000, PID_IN, 7'h04, 11'h00a, 16'h0080, 16'h0000);
        txn(1'b0, 16'h0000, PID_IN, 7'h08, 11'h00a, 16'h0004, 16'h0000);
        txn(1'b0, 16'h0000, PID_IN, 7'h60, 11'h00a, 16'h0002, 16'h0000);
        txn(1'b0, 16'h0010, PID_OUT, 7'h00, 11'h003, 16'h0001, 16'h0000);
        txn(1'b0, 16'h0010, PID_IN, 7'h08, 11'h00a, 16'h0004, 16'h0000);
    endtask

    task automatic scn_tokens;
        logic [3:0] codes [9];
        logic [1:0] r;
        codes = '{PID_SETUP, PID_IN, PID_OUT, PID_SOF, PID_PREAMBLE,
                  PID_NAK, PID_STALL, PID_DATA0, PID_DATA1};
        for (int i = 0; i < 9; i++) begin
            wr(IDX_H2_STATUS, {8'h00, codes[i], 4'(i + 7)}, r);
            chk({tok[1], ep[1], legal[1]}, {codes[i], 4'(i + 7), 1'b1});
        end
        wr(IDX_H2_STATUS, 16'h0020, r);
        chk({tok[1], ep[1], legal[1]}, 9'h040);
    endtask

    task automatic scn_address;
        logic [1:0]  r;
        logic [31:0] d;
        wr(IDX_H1_RESULT, 16'h0055, r);
        wr(IDX_H2_RESULT, 16'h002a, r);
        chk({taddr[1], taddr[0], r}, {7'h2a, 7'h55, RESP_OKAY});
        wr(IDX_H1_CONTROL + 18'h00002, 16'h0000, r);
        chk(r, RESP_SLVERR);
        rd(IDX_H1_CONTROL + 18'h00002, d, r);
        chk({d, r}, {32'h00000000, RESP_SLVERR});
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==================================================================
    // Clock, watchdog and main sequence
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // A hung handshake would otherwise stall the run forever.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 72'h0;
        {dly, flags, len} = 22'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        scn_length();
        scn_handshakes();
        scn_tokens();
        scn_address();
        conclude();
    end
endmodule
